// ===== rtl/dsp_core_ctrl_regs.svh
`ifndef DSP_CORE_CTRL_REGS_SVH
`define DSP_CORE_CTRL_REGS_SVH

// control port word addresses
`define ADDR_W 12
`define ADDR_IFACE_LO 12'h800
`define ADDR_IFACE_HI 12'h807
`define ADDR_PIN_SET 12'h808
`define ADDR_AUX_LO 12'h809
`define ADDR_AUX_HI 12'h80C
`define ADDR_SL_DATA_LO 12'h810
`define ADDR_SL_ADDR_LO 12'h815
`define ADDR_CAPTURE0 12'h81A
`define ADDR_CAPTURE1 12'h81B
`define ADDR_CORE_CTRL 12'h81C

// capture setup fields
`define CAP_SRC_LSB 0
`define CAP_SRC_MSB 1
`define CAP_STEP_LSB 2
`define CAP_STEP_MSB 11
`define CAP_SETUP_RESET 12'h000
`define CAP_DATA_RESET 24'h000000
// 5.23 word, 5.19 result: drop the four low bits
`define CORE_WORD_W 28
`define CAP_DATA_W 24
`define CAP_DROP_BITS 4

// core control fields
`define CC_RATE_LSB 0
`define CC_RATE_MSB 1
`define CC_CLEAR_N 2
`define CC_DAC_MUTE_N 3
`define CC_ADC_MUTE_N 4
`define CC_SAFELOAD 5
`define CC_IFACE_WO 6
`define CC_PIN_WO 7
`define CC_AUX_WO 8
`define CC_DEB_LSB 12
`define CC_DEB_MSB 13
`define CC_RESET 16'h0000
`define CC_WRITABLE 16'h31FF

// safeload pairs
`define SL_PAIRS 5

// timing
`define CLOCK_HZ 10000000
`define MS_PER_S 1000
`define DEB_MS_SEL0 20
`define DEB_MS_SEL1 40
`define DEB_MS_SEL2 10
`define DEB_MS_SEL3 5
`define DEB_CNT_W 20
`define IPS_W 11
`define IPS_1X 11'h400
`define IPS_2X 11'h200
`define IPS_4X 11'h100
`define IPS_RSVD 11'h000

`endif

// ===== rtl/dsp_core_ctrl_pkg.sv
package dsp_core_ctrl_pkg;
   // capture source encodings
   typedef enum logic [1:0] {
      SRC_MULT_X = 2'h0,
      SRC_MULT_Y = 2'h1,
      SRC_MAC = 2'h2,
      SRC_ACC_FB = 2'h3
   } capture_source_t;
   // safeload sequencer states
   typedef enum logic {SL_IDLE, SL_RUN} safeload_state_t;
endpackage : dsp_core_ctrl_pkg

// ===== rtl/safeload_sequencer.sv
`timescale 1ns/10ps
`include "dsp_core_ctrl_regs.svh"
module safeload_sequencer (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_sync_n,
   // pair writes and trigger
   input wire logic [`SL_PAIRS-1:0] i_pair_written,
   input wire logic i_start,
   input wire logic i_slot,
   // transfer side
   output logic o_busy,
   output logic o_done,
   output logic o_xfer_en,
   output logic [2:0] o_xfer_index,
   output logic [`SL_PAIRS-1:0] o_pending
);
   dsp_core_ctrl_pkg::safeload_state_t state_reg, state_next;
   logic [`SL_PAIRS-1:0] pending_reg, pending_next, take_mask;
   logic [2:0] pick;
   logic any_pending, step;

   // lowest pending pair first
   function automatic logic [2:0] lowest(input logic [`SL_PAIRS-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = `SL_PAIRS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : lowest

   // one pair per free core slot, only those written since last event
   assign any_pending = |pending_reg;
   assign pick = lowest(pending_reg);
   assign step = (state_reg == dsp_core_ctrl_pkg::SL_RUN) && i_slot && any_pending;
   assign take_mask = step ? (`SL_PAIRS'(1) << pick) : '0;
   // a fresh write wins over the transfer clearing it
   assign pending_next = (pending_reg & ~take_mask) | i_pair_written;

   // state decode
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dsp_core_ctrl_pkg::SL_IDLE: begin
            if (i_start) begin
               state_next = dsp_core_ctrl_pkg::SL_RUN;
            end
         end
         dsp_core_ctrl_pkg::SL_RUN: begin
            if (!any_pending) begin
               state_next = dsp_core_ctrl_pkg::SL_IDLE;
            end
         end
         default: state_next = dsp_core_ctrl_pkg::SL_IDLE;
      endcase
   end

   // state and outputs
   always_ff @(posedge i_clock or negedge i_rst_sync_n) begin
      if (!i_rst_sync_n) begin
         state_reg <= dsp_core_ctrl_pkg::SL_IDLE;
         pending_reg <= '0;
         o_xfer_en <= 1'b0;
         o_xfer_index <= 3'h0;
         o_done <= 1'b0;
      end else begin
         state_reg <= state_next;
         pending_reg <= pending_next;
         o_xfer_en <= step;
         o_xfer_index <= pick;
         o_done <= (state_reg == dsp_core_ctrl_pkg::SL_RUN) && !any_pending;
      end
   end

   assign o_busy = (state_reg == dsp_core_ctrl_pkg::SL_RUN);
   assign o_pending = pending_reg;

   a_pair_sent_once: assert property (@(posedge i_clock) disable iff (!i_rst_sync_n)
      step && !i_pair_written[pick] |=> !pending_reg[$past(pick)])
      else $error("transferred pair still pending");
endmodule : safeload_sequencer

// ===== rtl/dsp_capture_and_core_control.sv
`timescale 1ns/10ps
`include "dsp_core_ctrl_regs.svh"
module dsp_capture_and_core_control #(
   parameter logic [`DEB_CNT_W-1:0] DEB_CYC_SEL0 = `DEB_CNT_W'(`DEB_MS_SEL0 * (`CLOCK_HZ / `MS_PER_S)),
   parameter logic [`DEB_CNT_W-1:0] DEB_CYC_SEL1 = `DEB_CNT_W'(`DEB_MS_SEL1 * (`CLOCK_HZ / `MS_PER_S)),
   parameter logic [`DEB_CNT_W-1:0] DEB_CYC_SEL2 = `DEB_CNT_W'(`DEB_MS_SEL2 * (`CLOCK_HZ / `MS_PER_S)),
   parameter logic [`DEB_CNT_W-1:0] DEB_CYC_SEL3 = `DEB_CNT_W'(`DEB_MS_SEL3 * (`CLOCK_HZ / `MS_PER_S))
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // control port register access
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [`ADDR_W-1:0] i_addr,
   input wire logic [15:0] i_wr_data,
   output logic [`CAP_DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   // core program state
   input wire logic i_pc_valid,
   input wire logic [9:0] i_pc,
   input wire logic [`CORE_WORD_W-1:0] i_multiplier_x_operand,
   input wire logic [`CORE_WORD_W-1:0] i_multiplier_y_operand,
   input wire logic [`CORE_WORD_W-1:0] i_multiply_accumulate_result,
   input wire logic [`CORE_WORD_W-1:0] i_accumulator_feedback,
   input wire logic i_safeload_slot,
   // core control fields
   output logic [1:0] o_instruction_rate_select,
   output logic [`IPS_W-1:0] o_instructions_per_sample,
   output logic o_core_clear_n,
   output logic o_dac_mute_n,
   output logic o_adc_mute_n,
   output logic [1:0] o_gpio_debounce_select,
   output logic [`DEB_CNT_W-1:0] o_debounce_cycles,
   // write override controls
   output logic o_aux_wr_accept,
   output logic o_aux_ignore_pins,
   output logic o_pin_set_wr_accept,
   output logic o_pin_set_ignore_pins,
   output logic o_iface_wr_accept,
   output logic o_iface_program_block,
   // safeload transfer
   output logic o_safeload_busy,
   output logic o_safeload_xfer_en,
   output logic [2:0] o_safeload_xfer_index
);
   logic rst_meta_n, rst_sync_n;
   logic [11:0] setup_reg [2];
   logic [`CAP_DATA_W-1:0] cap_reg [2];
   logic [15:0] ctrl_reg, ctrl_next;
   logic [`CAP_DATA_W-1:0] rd_next;
   logic ctrl_wr, trig_start, sl_done;
   logic [`SL_PAIRS-1:0] pair_written;
   logic [`CORE_WORD_W-1:0] cap_word [2];
   logic cap_hit [2];
   logic cap_wr [2];

   // address window check used by several decoders
   function automatic logic in_range(input logic [`ADDR_W-1:0] a,
                                     input logic [`ADDR_W-1:0] lo,
                                     input logic [`ADDR_W-1:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   // reset release through two flops
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // capture channels
   for (genvar c = 0; c < 2; c++) begin : g_cap
      // setup write at this channel's address
      assign cap_wr[c] = i_wr_en && (i_addr == (`ADDR_CAPTURE0 + `ADDR_W'(c)));
      // source mux
      always_comb begin
         case (dsp_core_ctrl_pkg::capture_source_t'(setup_reg[c][`CAP_SRC_MSB:`CAP_SRC_LSB]))
            dsp_core_ctrl_pkg::SRC_MULT_X: cap_word[c] = i_multiplier_x_operand;
            dsp_core_ctrl_pkg::SRC_MULT_Y: cap_word[c] = i_multiplier_y_operand;
            dsp_core_ctrl_pkg::SRC_MAC: cap_word[c] = i_multiply_accumulate_result;
            dsp_core_ctrl_pkg::SRC_ACC_FB: cap_word[c] = i_accumulator_feedback;
            default: cap_word[c] = i_multiplier_x_operand;
         endcase
      end
      // step match
      assign cap_hit[c] = i_pc_valid && (i_pc == setup_reg[c][`CAP_STEP_MSB:`CAP_STEP_LSB]);

      // setup and captured value
      always_ff @(posedge i_clock or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            setup_reg[c] <= `CAP_SETUP_RESET;
            cap_reg[c] <= `CAP_DATA_RESET;
         end else begin
            if (cap_wr[c]) begin
               setup_reg[c] <= i_wr_data[`CAP_STEP_MSB:`CAP_SRC_LSB];
            end
            if (cap_hit[c]) begin
               cap_reg[c] <= cap_word[c][`CORE_WORD_W-1:`CAP_DROP_BITS];
            end
         end
      end

      a_capture_on_step: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
         cap_hit[c] |=> cap_reg[c] == $past(cap_word[c][`CORE_WORD_W-1:`CAP_DROP_BITS]))
         else $error("capture did not take the selected word");
      a_capture_holds: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
         !cap_hit[c] |=> $stable(cap_reg[c]))
         else $error("capture changed without a step match");
      a_setup_write: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
         cap_wr[c] |=> setup_reg[c] == $past(i_wr_data[`CAP_STEP_MSB:`CAP_SRC_LSB]))
         else $error("capture setup word not stored");
   end

   // control register write with trigger self-clear
   assign ctrl_wr = i_wr_en && (i_addr == `ADDR_CORE_CTRL);
   assign trig_start = ctrl_wr && i_wr_data[`CC_SAFELOAD] && !ctrl_reg[`CC_SAFELOAD];
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         // keep a pending trigger: software cannot cancel a running transfer
         ctrl_next = (i_wr_data & `CC_WRITABLE) | (ctrl_reg & (16'h1 << `CC_SAFELOAD));
      end
      if (sl_done) begin
         ctrl_next[`CC_SAFELOAD] = 1'b0;
      end
      if (trig_start) begin
         ctrl_next[`CC_SAFELOAD] = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl_reg <= `CC_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // field outputs
   assign o_instruction_rate_select = ctrl_reg[`CC_RATE_MSB:`CC_RATE_LSB];
   assign o_core_clear_n = ctrl_reg[`CC_CLEAR_N];
   assign o_dac_mute_n = ctrl_reg[`CC_DAC_MUTE_N];
   assign o_adc_mute_n = ctrl_reg[`CC_ADC_MUTE_N];
   assign o_gpio_debounce_select = ctrl_reg[`CC_DEB_MSB:`CC_DEB_LSB];

   // rate and debounce lookups, registered
   always_ff @(posedge i_clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_instructions_per_sample <= `IPS_1X;
         o_debounce_cycles <= DEB_CYC_SEL0;
      end else begin
         case (ctrl_next[`CC_RATE_MSB:`CC_RATE_LSB])
            2'h0: o_instructions_per_sample <= `IPS_1X;
            2'h1: o_instructions_per_sample <= `IPS_2X;
            2'h2: o_instructions_per_sample <= `IPS_4X;
            default: o_instructions_per_sample <= `IPS_RSVD;
         endcase
         case (ctrl_next[`CC_DEB_MSB:`CC_DEB_LSB])
            2'h0: o_debounce_cycles <= DEB_CYC_SEL0;
            2'h1: o_debounce_cycles <= DEB_CYC_SEL1;
            2'h2: o_debounce_cycles <= DEB_CYC_SEL2;
            default: o_debounce_cycles <= DEB_CYC_SEL3;
         endcase
      end
   end

   // write override decode
   assign o_aux_ignore_pins = ctrl_reg[`CC_AUX_WO];
   assign o_aux_wr_accept = i_wr_en && ctrl_reg[`CC_AUX_WO]
      && in_range(i_addr, `ADDR_AUX_LO, `ADDR_AUX_HI);
   assign o_pin_set_ignore_pins = ctrl_reg[`CC_PIN_WO];
   assign o_pin_set_wr_accept = i_wr_en && ctrl_reg[`CC_PIN_WO]
      && (i_addr == `ADDR_PIN_SET);
   assign o_iface_program_block = ctrl_reg[`CC_IFACE_WO];
   assign o_iface_wr_accept = i_wr_en && ctrl_reg[`CC_IFACE_WO]
      && in_range(i_addr, `ADDR_IFACE_LO, `ADDR_IFACE_HI);

   // safeload pair write marks, address or data word of a pair
   for (genvar p = 0; p < `SL_PAIRS; p++) begin : g_pair
      assign pair_written[p] = i_wr_en
         && ((i_addr == (`ADDR_SL_DATA_LO + `ADDR_W'(p)))
          || (i_addr == (`ADDR_SL_ADDR_LO + `ADDR_W'(p))));
   end

   safeload_sequencer u_safeload (
      .i_clock(i_clock),
      .i_rst_sync_n(rst_sync_n),
      .i_pair_written(pair_written),
      .i_start(trig_start),
      .i_slot(i_safeload_slot),
      .o_busy(o_safeload_busy),
      .o_done(sl_done),
      .o_xfer_en(o_safeload_xfer_en),
      .o_xfer_index(o_safeload_xfer_index),
      .o_pending()
   );

   // read mux, unmapped and reserved read zero; reads have no side effect
   always_comb begin
      rd_next = '0;
      if (i_addr == `ADDR_CAPTURE0) begin
         rd_next = cap_reg[0];
      end else if (i_addr == `ADDR_CAPTURE1) begin
         rd_next = cap_reg[1];
      end else if (i_addr == `ADDR_CORE_CTRL) begin
         rd_next = `CAP_DATA_W'(ctrl_reg);
      end
   end

   always_ff @(posedge i_clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_rd_data <= '0;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en) begin
            o_rd_data <= rd_next;
         end
      end
   end

   // control register and safeload checks
   a_trigger_sets: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      trig_start |=> ctrl_reg[`CC_SAFELOAD] && o_safeload_busy)
      else $error("safeload trigger did not start");
   a_trigger_self_clears: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      sl_done && !trig_start |=> !ctrl_reg[`CC_SAFELOAD])
      else $error("safeload trigger not cleared on completion");
   a_busy_holds_trigger: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_safeload_busy |-> ctrl_reg[`CC_SAFELOAD])
      else $error("safeload running with trigger bit clear");
   a_mutes_follow_bits: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      ctrl_wr && !trig_start && !sl_done |=> o_adc_mute_n == $past(i_wr_data[`CC_ADC_MUTE_N])
      && o_dac_mute_n == $past(i_wr_data[`CC_DAC_MUTE_N])
      && o_core_clear_n == $past(i_wr_data[`CC_CLEAR_N]))
      else $error("mute or clear bit did not follow the write");
   // rate and debounce lookups against their codes
   a_rate_default: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_instruction_rate_select == 2'h0 |-> o_instructions_per_sample == `IPS_1X)
      else $error("rate select 00 is not 1024 instructions");
   a_rate_double: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_instruction_rate_select == 2'h1 |-> o_instructions_per_sample == `IPS_2X)
      else $error("rate select 01 is not 512 instructions");
   a_rate_decode: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_instruction_rate_select == 2'h2 |-> o_instructions_per_sample == `IPS_4X)
      else $error("rate select 10 is not 256 instructions");
   a_rate_reserved: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_instruction_rate_select == 2'h3 |-> o_instructions_per_sample == `IPS_RSVD)
      else $error("reserved rate select not flagged");
   a_debounce_sel_zero: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_gpio_debounce_select == 2'h0 |-> o_debounce_cycles == DEB_CYC_SEL0)
      else $error("debounce select 00 wrong count");
   a_debounce_decode: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_gpio_debounce_select == 2'h1 |-> o_debounce_cycles == DEB_CYC_SEL1)
      else $error("debounce select 01 wrong count");
   a_debounce_sel_two: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_gpio_debounce_select == 2'h2 |-> o_debounce_cycles == DEB_CYC_SEL2)
      else $error("debounce select 10 wrong count");
   a_debounce_sel_three: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_gpio_debounce_select == 2'h3 |-> o_debounce_cycles == DEB_CYC_SEL3)
      else $error("debounce select 11 wrong count");
   // write override gating
   a_aux_gated: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      o_aux_wr_accept |-> o_aux_ignore_pins && i_addr >= `ADDR_AUX_LO
      && i_addr <= `ADDR_AUX_HI)
      else $error("aux write accepted without override");
   a_aux_range_end: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      i_wr_en && i_addr == `ADDR_AUX_HI |-> o_aux_wr_accept == ctrl_reg[`CC_AUX_WO])
      else $error("aux write at last address wrong");
   a_iface_gated: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      i_wr_en && i_addr == `ADDR_IFACE_LO |-> o_iface_wr_accept == o_iface_program_block)
      else $error("interface write acceptance wrong");
   a_iface_range_end: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      i_wr_en && i_addr == `ADDR_IFACE_HI |-> o_iface_wr_accept == ctrl_reg[`CC_IFACE_WO])
      else $error("interface write at last address wrong");
   a_pin_gated: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      i_wr_en && i_addr == `ADDR_PIN_SET |-> o_pin_set_wr_accept == ctrl_reg[`CC_PIN_WO])
      else $error("pin setting write acceptance wrong");
   // capture reads
   a_capture_read: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      i_rd_en && i_addr == `ADDR_CAPTURE1 |=> o_rd_valid && o_rd_data == $past(cap_reg[1]))
      else $error("capture 1 read returned wrong data");
   a_capture_zero_read: assert property (@(posedge i_clock) disable iff (!rst_sync_n)
      i_rd_en && i_addr == `ADDR_CAPTURE0 |=> o_rd_valid && o_rd_data == $past(cap_reg[0]))
      else $error("capture 0 read returned wrong data");
endmodule : dsp_capture_and_core_control

// ===== verif/host_model.sv
`timescale 1ns/10ps
`include "dsp_core_ctrl_regs.svh"
module host_model (
   // clock
   input wire logic i_clock,
   // control port requests
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [`ADDR_W-1:0] o_addr,
   output logic [15:0] o_wr_data,
   // read answer
   input wire logic [`CAP_DATA_W-1:0] i_rd_data,
   input wire logic i_rd_valid
);
   // idle port after power-up
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 12'h000;
      o_wr_data = 16'h0000;
   end

   // one word write; released lines show the inverse, not the old value
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge i_clock);
      o_wr_en <= 1'b1;
      o_addr <= a;
      o_wr_data <= d;
      @(posedge i_clock);
      o_wr_en <= 1'b0;
      o_addr <= ~a;
      o_wr_data <= ~d;
   endtask : wr

   // one word read; answer must stand half a cycle after the strobe edge
   task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`CAP_DATA_W-1:0] d);
      @(posedge i_clock);
      o_rd_en <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      @(negedge i_clock);
      d = (i_rd_valid === 1'b1) ? i_rd_data : 'x;
   endtask : rd
endmodule : host_model

// ===== verif/testbench.sv
`timescale 1ns/10ps
`include "dsp_core_ctrl_regs.svh"
module testbench;
   logic i_clock, rst_n, wr_en, rd_en, rd_valid, pc_valid, slot;
   logic [`ADDR_W-1:0] addr;
   logic [15:0] wr_data;
   logic [23:0] rd_data, r;
   logic [9:0] pc;
   logic [`CORE_WORD_W-1:0] w [4];
   logic [1:0] rate_sel, deb_sel;
   logic [10:0] ips;
   logic [19:0] deb_cyc;
   logic clr_n, dac_n, adc_n, aux_acc, aux_ign, pin_acc, pin_ign, if_acc, if_blk;
   logic sl_busy, sl_xen;
   logic [2:0] sl_idx;
   int bad_count, cmp_count;
   logic [23:0] deb_t [4] = '{24'h14, 24'h28, 24'h0A, 24'h05};
   logic [23:0] ips_t [4] = '{24'h400, 24'h200, 24'h100, 24'h000};
   logic [11:0] ta [6] = '{12'h800, 12'h807, 12'h808, 12'h809, 12'h80C, 12'h80D};

   host_model i_host (.i_clock(i_clock), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
      .o_wr_data(wr_data), .i_rd_data(rd_data), .i_rd_valid(rd_valid));

   dsp_capture_and_core_control #(.DEB_CYC_SEL0(20'h14), .DEB_CYC_SEL1(20'h28),
      .DEB_CYC_SEL2(20'h0A), .DEB_CYC_SEL3(20'h05)) i_dut (
      .i_clock(i_clock), .i_rstn(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
      .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
      .i_pc_valid(pc_valid), .i_pc(pc), .i_multiplier_x_operand(w[0]),
      .i_multiplier_y_operand(w[1]), .i_multiply_accumulate_result(w[2]),
      .i_accumulator_feedback(w[3]), .i_safeload_slot(slot),
      .o_instruction_rate_select(rate_sel), .o_instructions_per_sample(ips),
      .o_core_clear_n(clr_n), .o_dac_mute_n(dac_n), .o_adc_mute_n(adc_n),
      .o_gpio_debounce_select(deb_sel), .o_debounce_cycles(deb_cyc),
      .o_aux_wr_accept(aux_acc), .o_aux_ignore_pins(aux_ign), .o_pin_set_wr_accept(pin_acc),
      .o_pin_set_ignore_pins(pin_ign), .o_iface_wr_accept(if_acc),
      .o_iface_program_block(if_blk), .o_safeload_busy(sl_busy),
      .o_safeload_xfer_en(sl_xen), .o_safeload_xfer_index(sl_idx));

   // core clock, 100 ns period
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   // compare and report
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // verdict and end of run
   task automatic stop_test();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // accept strobes seen during a write
   task automatic chk_acc(input logic [11:0] a, input logic [2:0] ov);
      logic [2:0] e;
      e = {ov[2] && a >= 12'h809 && a <= 12'h80C, ov[1] && a == 12'h808, ov[0] && a <= 12'h807};
      fork
         i_host.wr(a, 16'h0000);
         begin
            @(posedge i_clock);
            @(negedge i_clock);
            chk(24'({aux_acc, pin_acc, if_acc}), 24'(e));
         end
      join
   endtask : chk_acc

   // values straight after reset
   task automatic t_reset();
      i_host.rd(12'h81C, r);
      chk(r, 24'h000000);
      chk(24'({adc_n, dac_n, clr_n}), 24'h0);
      chk(24'(ips), 24'h400);
      chk(24'(deb_cyc), 24'h14);
   endtask : t_reset

   // every rate and debounce code, override codes 1 to 4; reserved bits dropped
   task automatic t_ctrl();
      logic [15:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {2'h0, 2'(i), 3'h0, 3'(i + 1), 1'h0, 3'(i * 5), 2'(i)};
         i_host.wr(12'h81C, v | 16'hCE00);
         i_host.rd(12'h81C, r);
         chk(r, {8'h00, v});
         chk(24'({deb_sel, rate_sel}), 24'({2'(i), 2'(i)}));
         chk(24'(deb_cyc), deb_t[i]);
         chk(24'(ips), ips_t[i]);
         chk(24'({aux_ign, pin_ign, if_blk}), 24'(v[8:6]));
         chk(24'({adc_n, dac_n, clr_n}), 24'(v[4:2]));
         for (int k = 0; k < 6; k++) chk_acc(ta[k], v[8:6]);
      end
   endtask : t_ctrl

   // each source once, step boundaries, both registers independent
   task automatic t_capture();
      logic [9:0] st;
      logic [27:0] t;
      logic [23:0] ex [2];
      ex = '{24'h000000, 24'h000000};
      for (int s = 0; s < 4; s++) begin
         st = (s == 3) ? 10'h3FF : 10'(s * 100);
         i_host.wr(12'h81A + 12'(s % 2), {4'h0, st, 2'(s)});
         @(posedge i_clock);
         for (int k = 0; k < 4; k++) w[k] <= 28'(32'h0ABCDEF + k * 32'h1234567 + s * 32'h10);
         pc <= st ^ 10'h001;
         pc_valid <= 1'b1;
         @(posedge i_clock);
         pc <= st;
         @(posedge i_clock);
         pc_valid <= 1'b0;
         pc <= ~st;
         for (int k = 0; k < 4; k++) w[k] <= ~w[k];
         t = 28'(32'h0ABCDEF + s * 32'h1234567 + s * 32'h10);
         ex[s % 2] = t[27:4];
         // reset setup of the second register is step 0 source 0 as well
         if (s == 0) ex[1] = ex[0];
         for (int j = 0; j < 2; j++) begin
            i_host.rd(12'h81A + 12'(j), r);
            chk(r, ex[j]);
         end
      end
   endtask : t_capture

   // pairs 0 and 2 written, sent lowest first, bit self-clears
   task automatic t_safeload();
      logic [2:0] g;
      logic [2:0] xe [3];
      xe = '{3'h0, 3'h2, 3'h7};
      i_host.wr(12'h812, 16'h1234);
      i_host.wr(12'h815, 16'h0055);
      i_host.wr(12'h81C, 16'h0020);
      i_host.wr(12'h81C, 16'h0000);
      i_host.rd(12'h81C, r);
      chk(r, 24'h000020);
      chk(24'(sl_busy), 24'h1);
      for (int n = 0; n < 3; n++) begin
         @(posedge i_clock);
         slot <= 1'b1;
         @(posedge i_clock);
         slot <= 1'b0;
         g = 3'h7;
         repeat (3) begin
            @(negedge i_clock);
            if (sl_xen === 1'b1) g = sl_idx;
         end
         chk(24'(g), 24'(xe[n]));
      end
      chk(24'(sl_busy), 24'h0);
      i_host.rd(12'h81C, r);
      chk(r, 24'h000000);
      // a second event finds nothing written since the first
      i_host.wr(12'h81C, 16'h0020);
      @(posedge i_clock);
      slot <= 1'b1;
      @(posedge i_clock);
      slot <= 1'b0;
      g = 3'h7;
      repeat (3) begin
         @(negedge i_clock);
         if (sl_xen === 1'b1) g = sl_idx;
      end
      chk(24'(g), 24'h000007);
      i_host.rd(12'h81C, r);
      chk(r, 24'h000000);
   endtask : t_safeload

   // reset, then the scenarios
   initial begin
      rst_n = 1'b0;
      pc_valid = 1'b0;
      pc = 10'h000;
      slot = 1'b0;
      for (int k = 0; k < 4; k++) w[k] = 28'h0000000;
      bad_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge i_clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      t_reset();
      t_ctrl();
      t_capture();
      t_safeload();
      stop_test();
   end

   // watchdog against a hung handshake
   initial begin
      #500000;
      bad_count++;
      stop_test();
   end
endmodule : testbench
